// ===== design/sram_port.v
// Burst-of-two double-data-rate SRAM port logic with read-data buffer.
`timescale 1ns/10ps
`default_nettype none
`include "sram_port_defs.vh"

// Read-data buffer: registered storage, valid and ready on both sides.
module rd_buffer #(
	parameter WIDTH = 36,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire i_ref_clk, // System clock.
	input wire i_rst_b, // Asynchronous reset, active low.
	input wire i_in_valid, // Word offered.
	output wire o_in_ready, // Room for a word.
	input wire [WIDTH-1:0] i_in_data, // Word written.
	output wire o_out_valid, // Word available.
	input wire i_out_ready, // Consumer takes the word.
	output wire [WIDTH-1:0] o_out_data // Oldest word.
);
	reg [WIDTH-1:0] store [0:DEPTH-1];
	reg [AW:0] wptr_q;
	reg [AW:0] rptr_q;
	wire push;
	wire pop;

	// An extra pointer bit tells full from empty without a separate counter.
	assign o_out_valid = (wptr_q != rptr_q);
	assign o_in_ready = (wptr_q[AW-1:0] != rptr_q[AW-1:0]) || (wptr_q[AW] == rptr_q[AW]);
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;
	assign o_out_data = store[rptr_q[AW-1:0]];

	// Storage is not reset; only the pointers carry state.
	always @(posedge i_ref_clk) begin
		if (push) begin
			store[wptr_q[AW-1:0]] <= i_in_data;
		end
	end

	// Pointer update.
	always @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wptr_q <= {(AW+1){1'b0}};
			rptr_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wptr_q <= wptr_q + 1'b1;
			end
			if (pop) begin
				rptr_q <= rptr_q + 1'b1;
			end
		end
	end
endmodule

// Function
// - Counter periodically triggers impedance evaluation, repeats.
// - Each evaluation moves drive one step unless the code is already at its end in that direction.
// - Drive strength is binary weighted code.
// - Read after completed write returns new data.
// - Same-cycle read/write address pair forwards newest data.
// - Read beats at next C-bar and C, or at next K and K-bar with output clocks tied.
// - Write beat one at K, address/beat two at K-bar.
// - Write select high ignores whole cycle.
// - Low mask writes lane; high mask leaves that lane unchanged.
// - x36 four byte masks gate nine-bit lanes.
// - x18 two byte masks gate nine-bit lanes.
// - x8 two nybble masks gate four-bit lanes.
// - One-bit linear burst: even then odd.
// - Read and write machines run independently.
// - Machine transitions timed by primary timing input; read fetch steps after RF_WAIT follow the system clock and buffer ready.
// - Output clocks tied high launch from K.
// - Burst in progress always completes both beats.
module sram_port (
	input wire i_ref_clk, // System clock, 50 MHz.
	input wire i_rst_b, // Asynchronous reset, active low.
	input wire [1:0] i_org, // Organisation strap, caught after reset.
	input wire i_k, // Primary timing input.
	input wire i_k_n, // Complementary primary timing input.
	input wire i_c, // Output timing input.
	input wire i_c_n, // Complementary output timing input.
	input wire i_read_select_n, // Read command, active low.
	input wire i_write_select_n, // Write command, active low.
	input wire [`ADDR_W-1:0] i_addr, // Shared burst address.
	input wire [`DATA_W-1:0] i_data, // Write data.
	input wire [3:0] i_byte_write_mask_n, // Byte masks, active low.
	input wire [1:0] i_nybble_write_mask_n, // Nybble masks for x8, active low.
	input wire i_impedance_ref_pin, // Comparator: high when drive is too weak.
	output reg [`DATA_W-1:0] o_q, // Read data.
	output reg o_q_oe, // Read data driven.
	output reg o_echo_timing_out, // Echo of the launching clock.
	output reg o_echo_timing_out_n, // Inverted echo.
	output reg [`IMP_CODE_W-1:0] o_drive_code, // Output driver impedance code.
	output wire o_rdbuf_ready // Read buffer can take a word.
);
	// The interval is kept as an integer and cut to the counter width on purpose.
	localparam integer IMP_LAST_I = `IMP_CYCLES - 1;
	localparam [`IMP_CNT_W-1:0] IMP_LAST = IMP_LAST_I[`IMP_CNT_W-1:0];

	reg [`PIN_W-1:0] s1_q;
	reg [`PIN_W-1:0] s2_q;
	reg [`PIN_W-1:0] s3_q;
	reg [`PIN_W-1:0] f_q;
	wire [`PIN_W-1:0] f_d;
	wire [`PIN_W-1:0] pins;
	reg [1:0] org_q;
	reg org_taken_q;
	reg [`DATA_W-1:0] mem_even [0:(1<<`ADDR_W)-1];
	reg [`DATA_W-1:0] mem_odd [0:(1<<`ADDR_W)-1];
	reg wr_act_q;
	reg [`DATA_W-1:0] wr_d0_q;
	reg [`DATA_W-1:0] wr_en0_q;
	reg rd_act_q;
	reg [`ADDR_W-1:0] rd_addr_q;
	reg [1:0] rf_q;
	reg beat2_q;
	reg [`IMP_CNT_W-1:0] imp_cnt_q;
	wire k_rise;
	wire kn_rise;
	wire c_rise;
	wire cn_rise;
	wire c_tied;
	wire launch1;
	wire launch2;
	wire [`DATA_W-1:0] din;
	wire [`ADDR_W-1:0] addr;
	wire [`DATA_W-1:0] lane_en;
	wire [`ADDR_W-1:0] wr_addr;
	reg buf_valid;
	reg [`DATA_W-1:0] buf_data;
	wire buf_out_valid;
	wire [`DATA_W-1:0] buf_out_data;
	wire buf_pop;

	assign pins = {1'b0, i_k, i_k_n, i_c, i_c_n, i_read_select_n, i_write_select_n,
		i_impedance_ref_pin, i_nybble_write_mask_n, i_byte_write_mask_n, i_addr, i_data};

	// Every pin passes three flops; a bit moves only when stages two and three agree.
	genvar g;
	generate
		for (g = 0; g < `PIN_W; g = g + 1) begin : g_filt
			assign f_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : f_q[g];
		end
	endgenerate

	// Synchroniser chain and filtered pin image.
	always @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s1_q <= {`PIN_W{1'b0}};
			s2_q <= {`PIN_W{1'b0}};
			s3_q <= {`PIN_W{1'b0}};
			f_q <= {`PIN_W{1'b0}};
		end else begin
			s1_q <= pins;
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q <= f_d;
		end
	end

	// Clock edges as seen through the filter; data is taken from the same stage.
	assign k_rise = f_d[`P_K] & ~f_q[`P_K];
	assign kn_rise = f_d[`P_KN] & ~f_q[`P_KN];
	assign c_rise = f_d[`P_C] & ~f_q[`P_C];
	assign cn_rise = f_d[`P_CN] & ~f_q[`P_CN];
	assign din = f_d[`P_DATA +: `DATA_W];
	assign addr = f_d[`P_ADDR +: `ADDR_W];
	assign wr_addr = addr;

	// Complementary clocks are never both high unless strapped; then K launches.
	assign c_tied = f_d[`P_C] & f_d[`P_CN];
	assign launch1 = c_tied ? k_rise : cn_rise;
	assign launch2 = c_tied ? kn_rise : c_rise;

	// The strap is caught by a clocked process after reset release, never by reset.
	always @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			org_q <= `ORG_X36;
			org_taken_q <= 1'b0;
		end else if (!org_taken_q) begin
			org_q <= i_org;
			org_taken_q <= 1'b1;
		end
	end

	// Lane enables per bit from the masks of the current beat and organisation.
	generate
		for (g = 0; g < `DATA_W; g = g + 1) begin : g_lane
			if (g < 8) begin : g_low
				assign lane_en[g] = (org_q == `ORG_X8) ?
					~f_d[`P_NMASK + g/4] : ~f_d[`P_BMASK + g/9];
			end else if (g < 18) begin : g_mid
				assign lane_en[g] = (org_q != `ORG_X8) & ~f_d[`P_BMASK + g/9];
			end else begin : g_high
				assign lane_en[g] = (org_q == `ORG_X36) & ~f_d[`P_BMASK + g/9];
			end
		end
	endgenerate

	// Write machine: beat one at K, address and beat two at K-bar, then commit.
	always @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_act_q <= 1'b0;
			wr_d0_q <= {`DATA_W{1'b0}};
			wr_en0_q <= {`DATA_W{1'b0}};
		end else if (k_rise && !wr_act_q) begin
			wr_act_q <= ~f_d[`P_WSEL];
			wr_d0_q <= din;
			wr_en0_q <= f_d[`P_WSEL] ? {`DATA_W{1'b0}} : lane_en;
		end else if (kn_rise && wr_act_q) begin
			wr_act_q <= 1'b0;
		end
	end

	// Both beats land together, even word first in burst order; masked bits stay.
	always @(posedge i_ref_clk) begin
		if (kn_rise && wr_act_q) begin
			mem_even[wr_addr] <= (mem_even[wr_addr] & ~wr_en0_q) | (wr_d0_q & wr_en0_q);
			mem_odd[wr_addr] <= (mem_odd[wr_addr] & ~lane_en) | (din & lane_en);
		end
	end

	// Read machine: command at K, fetch after K-bar so a write to the same
	// address in that cycle is already in the array and is read back.
	always @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rd_act_q <= 1'b0;
			rd_addr_q <= {`ADDR_W{1'b0}};
			rf_q <= `RF_IDLE;
		end else begin
			if (k_rise && !rd_act_q) begin
				rd_act_q <= ~f_d[`P_RSEL];
				rd_addr_q <= addr;
			end
			case (rf_q)
				`RF_IDLE: begin
					if (rd_act_q && kn_rise) begin
						rf_q <= `RF_WAIT;
					end
				end
				`RF_WAIT: begin
					rf_q <= `RF_BEAT0;
				end
				`RF_BEAT0: begin
					if (o_rdbuf_ready) begin
						rf_q <= `RF_BEAT1;
					end
				end
				`RF_BEAT1: begin
					if (o_rdbuf_ready) begin
						rf_q <= `RF_IDLE;
						rd_act_q <= 1'b0;
					end
				end
				default: begin
					rf_q <= `RF_IDLE;
				end
			endcase
		end
	end

	// Buffer feed: even word, then odd word of the burst.
	always @* begin
		buf_valid = (rf_q == `RF_BEAT0) || (rf_q == `RF_BEAT1);
		buf_data = (rf_q == `RF_BEAT1) ? mem_odd[rd_addr_q] : mem_even[rd_addr_q];
	end

	rd_buffer #(
		.WIDTH(`DATA_W),
		.DEPTH(`RDBUF_DEPTH),
		.AW(`RDBUF_AW)
	) u_rd_buffer (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_in_valid(buf_valid),
		.o_in_ready(o_rdbuf_ready),
		.i_in_data(buf_data),
		.o_out_valid(buf_out_valid),
		.i_out_ready(buf_pop),
		.o_out_data(buf_out_data)
	);

	// Words leave the buffer only on launch edges, which back-pressures the fetch.
	assign buf_pop = buf_out_valid & (launch1 | (launch2 & beat2_q));

	// Output launch: first beat on the first launch edge, second on the next.
	always @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_q <= {`DATA_W{1'b0}};
			o_q_oe <= 1'b0;
			beat2_q <= 1'b0;
		end else if (launch1) begin
			o_q_oe <= buf_out_valid;
			beat2_q <= buf_out_valid;
			if (buf_out_valid) begin
				o_q <= buf_out_data;
			end
		end else if (launch2 && beat2_q) begin
			beat2_q <= 1'b0;
			if (buf_out_valid) begin
				o_q <= buf_out_data;
			end
		end
	end

	// Echo outputs follow whichever pair fires the output registers.
	always @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_echo_timing_out <= 1'b0;
			o_echo_timing_out_n <= 1'b1;
		end else begin
			o_echo_timing_out <= c_tied ? f_q[`P_K] : f_q[`P_C];
			o_echo_timing_out_n <= c_tied ? f_q[`P_KN] : f_q[`P_CN];
		end
	end

	// Recalibration: one step per evaluation, saturating, so a noisy comparator
	// can only dither the drive by a single binary-weighted step.
	always @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			imp_cnt_q <= {`IMP_CNT_W{1'b0}};
			o_drive_code <= `IMP_CODE_RESET;
		end else if (imp_cnt_q == IMP_LAST) begin
			imp_cnt_q <= {`IMP_CNT_W{1'b0}};
			if (f_q[`P_REF] && o_drive_code != `IMP_CODE_MAX) begin
				o_drive_code <= o_drive_code + 1'b1;
			end else if (!f_q[`P_REF] && o_drive_code != {`IMP_CODE_W{1'b0}}) begin
				o_drive_code <= o_drive_code - 1'b1;
			end
		end else begin
			imp_cnt_q <= imp_cnt_q + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== design/sram_port_defs.vh
// Constants for the burst-of-two separate-I/O double-data-rate SRAM port.
`ifndef SRAM_PORT_DEFS_VH
`define SRAM_PORT_DEFS_VH
// Data and address widths.
`define DATA_W 36
`define ADDR_W 8
// Organisation strap codes.
`define ORG_X36 2'h0
`define ORG_X18 2'h1
`define ORG_X8 2'h2
// Positions in the synchronised pin vector.
`define PIN_W 58
`define P_DATA 0
`define P_ADDR 36
`define P_BMASK 44
`define P_NMASK 48
`define P_REF 50
`define P_WSEL 51
`define P_RSEL 52
`define P_CN 53
`define P_C 54
`define P_KN 55
`define P_K 56
`define P_SPARE 57
// Impedance recalibration interval and driver code.
`define CLK_PERIOD_NS 20
`define IMP_INTERVAL_NS 20480
`define IMP_CYCLES (`IMP_INTERVAL_NS / `CLK_PERIOD_NS)
`define IMP_CNT_W 11
`define IMP_CODE_W 5
`define IMP_CODE_RESET 5'h10
`define IMP_CODE_MAX 5'h1F
// Read-data buffer.
`define RDBUF_DEPTH 16
`define RDBUF_AW 4
// Read fetch states.
`define RF_IDLE 2'h0
`define RF_WAIT 2'h1
`define RF_BEAT0 2'h2
`define RF_BEAT1 2'h3
`endif

// ===== testbench/sram_port_props.sv
// Checker for the impedance code, read outputs and echo timing of the port.
`timescale 1ns/10ps
`default_nettype none
`include "sram_port_defs.vh"
module sram_port_props (
	input wire logic i_ref_clk, // System clock.
	input wire logic i_rst_b, // Reset, active low.
	input wire logic i_k, // Primary timing.
	input wire logic i_k_n, // Complementary timing.
	input wire logic i_impedance_ref_pin, // Comparator level.
	input wire logic [`DATA_W-1:0] o_q, // Read data.
	input wire logic o_q_oe, // Read data driven.
	input wire logic o_echo_timing_out, // Echo.
	input wire logic o_echo_timing_out_n, // Inverted echo.
	input wire logic [`IMP_CODE_W-1:0] o_drive_code // Driver code.
);
	logic [10:0] gap_q;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	// Cycles since the code last moved; it saturates so it never wraps into a false gap.
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			gap_q <= 11'h000;
		else if (o_drive_code != $past(o_drive_code))
			gap_q <= 11'h000;
		else if (gap_q != 11'h7FF)
			gap_q <= gap_q + 11'h001;
	end
	code_step_a: assert property ($changed(o_drive_code) |->
		(o_drive_code - $past(o_drive_code) == 5'h01) || ($past(o_drive_code) - o_drive_code == 5'h01))
		else $error("drive code moved more than one step");
	code_sat_a: assert property ($changed(o_drive_code) |->
		!(($past(o_drive_code) == 5'h1F && o_drive_code == 5'h00) ||
		($past(o_drive_code) == 5'h00 && o_drive_code == 5'h1F)))
		else $error("drive code wrapped");
	code_gap_a: assert property ($changed(o_drive_code) |-> gap_q >= 11'h3E8)
		else $error("drive code moved too soon");
	code_dir_a: assert property (
		($changed(o_drive_code) && $past(i_impedance_ref_pin, 5) == $past(i_impedance_ref_pin, 20))
		|-> ((o_drive_code == $past(o_drive_code) + 5'h01) == $past(i_impedance_ref_pin, 5)))
		else $error("drive code moved against the comparator");
	oe_hold_a: assert property ($rose(o_q_oe) |-> o_q_oe [*8])
		else $error("read data enable dropped inside a burst");
	q_hold_a: assert property ($changed(o_q) |=> $stable(o_q) [*4])
		else $error("read data changed between launches");
	echo_k_a: assert property ($stable(i_k) [*8] |-> o_echo_timing_out == i_k)
		else $error("echo does not follow the primary timing");
	echo_kn_a: assert property ($stable(i_k_n) [*8] |-> o_echo_timing_out_n == i_k_n)
		else $error("inverted echo does not follow the timing");
endmodule
bind sram_port sram_port_props u_sram_port_props (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
	.i_k(i_k), .i_k_n(i_k_n), .i_impedance_ref_pin(i_impedance_ref_pin), .o_q(o_q),
	.o_q_oe(o_q_oe), .o_echo_timing_out(o_echo_timing_out),
	.o_echo_timing_out_n(o_echo_timing_out_n), .o_drive_code(o_drive_code));
`default_nettype wire

// ===== testbench/ctrl_model.sv
// Memory controller model that drives the timing pins and command bursts.
`timescale 1ns/10ps
`default_nettype none
`include "sram_port_defs.vh"
module ctrl_model (
	input wire logic i_ref_clk, // System clock.
	input wire logic [`DATA_W-1:0] i_q, // Read data.
	input wire logic i_q_oe, // Read data driven.
	output logic o_k, // Primary timing.
	output logic o_k_n, // Complementary timing.
	output logic o_rsel_n, // Read command.
	output logic o_wsel_n, // Write command.
	output logic [7:0] o_addr, // Burst address.
	output logic [`DATA_W-1:0] o_data, // Write data.
	output logic [3:0] o_bm_n, // Byte masks.
	output logic [1:0] o_nm_n // Nybble masks.
);
	// Idle with K low and both selects high, so release of reset sees no command.
	initial begin
		{o_k, o_k_n, o_rsel_n, o_wsel_n, o_addr, o_data, o_nm_n, o_bm_n} = {4'h7, 44'h0, 6'h3F};
	end
	// One K period of sixteen clocks; halves of eight leave room for the pin filter.
	task automatic cycle(input logic rs_n, ws_n, input logic [7:0] ra, wa,
		input logic [`DATA_W-1:0] d0, d1, input logic [5:0] m0, m1,
		output logic [`DATA_W-1:0] q0, q1, output logic oe0, oe1);
		@(posedge i_ref_clk) #2;
		{o_k, o_k_n, o_rsel_n, o_wsel_n, o_addr, o_data} = {2'b10, rs_n, ws_n, ra, d0};
		{o_nm_n, o_bm_n} = m0;
		repeat (7) @(posedge i_ref_clk);
		#2 {q0, oe0} = {i_q, i_q_oe};
		@(posedge i_ref_clk) #2;
		{o_k, o_k_n, o_addr, o_data, o_nm_n, o_bm_n} = {2'b01, wa, d1, m1};
		repeat (7) @(posedge i_ref_clk);
		#2 {q1, oe1} = {i_q, i_q_oe};
	endtask
endmodule
`default_nettype wire

// ===== testbench/sram_port_tb_top.sv
// Self-checking bench: random traffic in all three organisations, then recalibration.
`timescale 1ns/10ps
`default_nettype none
`include "sram_port_defs.vh"
module sram_port_tb_top;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [1:0] org = 2'h0;
	logic imp_ref = 1'b0;
	logic k, k_n, rsel_n, wsel_n, q_oe, pend, rdy;
	logic [7:0] addr;
	logic [`DATA_W-1:0] data, q, e0, e1, wm;
	logic [3:0] bm_n;
	logic [1:0] nm_n;
	logic [`IMP_CODE_W-1:0] code;
	logic [`DATA_W-1:0] mem [0:15];
	logic [31:0] r;
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	always #10 ref_clk = ~ref_clk;
	sram_port u_sram_port (.i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_org(org), .i_k(k),
		.i_k_n(k_n), .i_c(1'b1), .i_c_n(1'b1), .i_read_select_n(rsel_n),
		.i_write_select_n(wsel_n), .i_addr(addr), .i_data(data), .i_byte_write_mask_n(bm_n),
		.i_nybble_write_mask_n(nm_n), .i_impedance_ref_pin(imp_ref), .o_q(q), .o_q_oe(q_oe),
		.o_echo_timing_out(), .o_echo_timing_out_n(), .o_drive_code(code), .o_rdbuf_ready(rdy));
	ctrl_model u_ctrl_model (.i_ref_clk(ref_clk), .i_q(q), .i_q_oe(q_oe), .o_k(k), .o_k_n(k_n),
		.o_rsel_n(rsel_n), .o_wsel_n(wsel_n), .o_addr(addr), .o_data(data), .o_bm_n(bm_n),
		.o_nm_n(nm_n));
	task automatic conclude();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input string name, input logic [`DATA_W-1:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Lanes a mask bit lets through; the x8 lanes are nybbles, the others nine-bit bytes.
	function automatic logic [`DATA_W-1:0] merge(input logic [`DATA_W-1:0] old, d,
		input logic [5:0] m);
		logic [`DATA_W-1:0] res;
		res = old;
		for (int i = 0; i < `DATA_W; i++) begin
			if (org == 2'h2 ? (i < 8 && !m[4 + i / 4]) : (!m[i / 9] && (org == 2'h0 || i < 18)))
				res[i] = d[i];
		end
		return res;
	endfunction
	// A burst: beats of the previous read are checked, then this cycle's write and read.
	task automatic step(input logic rd, wr, input logic [2:0] ra, wa, input logic [5:0] m0, m1);
		logic [`DATA_W-1:0] d0, d1, q0, q1;
		logic oe0, oe1;
		d0 = `DATA_W'({$urandom(), $urandom()});
		d1 = `DATA_W'({$urandom(), $urandom()});
		u_ctrl_model.cycle(!rd, !wr, {5'h00, ra}, {5'h00, wa}, d0, d1, m0, m1, q0, q1, oe0, oe1);
		check("enable0", {35'h0, oe0}, {35'h0, pend});
		check("enable1", {35'h0, oe1}, {35'h0, pend});
		if (pend) begin
			check("beat0", q0 & wm, e0 & wm);
			check("beat1", q1 & wm, e1 & wm);
		end
		if (wr) begin
			mem[{wa, 1'b0}] = merge(mem[{wa, 1'b0}], d0, m0);
			mem[{wa, 1'b1}] = merge(mem[{wa, 1'b1}], d1, m1);
		end
		{pend, e0, e1} = {rd, mem[{ra, 1'b0}], mem[{ra, 1'b1}]};
	endtask
	// A hang ends the run as a mismatch once the expected length is well exceeded.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 70000) begin
			failures++;
			conclude();
		end
	end
	initial begin
		r = $urandom(32'h8405);
		for (int o = 0; o < 3; o++) begin
			#2 {rst_b, org, pend} = {1'b0, 2'(o), 1'b0};
			wm = o == 0 ? 36'hF_FFFF_FFFF : (o == 1 ? 36'h0_0003_FFFF : 36'h0_0000_00FF);
			repeat (6) @(posedge ref_clk);
			#2 rst_b = 1'b1;
			repeat (1024) @(posedge ref_clk);
			for (int a = 0; a < 8; a++)
				step(1'b0, 1'b1, 3'h0, 3'(a), 6'h00, 6'h00);
			step(1'b1, 1'b1, 3'h3, 3'h3, 6'h3F, 6'h00);
			for (int n = 0; n < 24; n++) begin
				r = $urandom();
				step(r[0], r[1], r[4:2], r[7:5], r[13:8], r[19:14]);
			end
			step(1'b0, 1'b0, 3'h0, 3'h0, 6'h3F, 6'h3F);
		end
		repeat (17 * 1024 + 64) @(posedge ref_clk);
		check("rdbuf_ready", {35'h0, rdy}, 36'h0_0000_0001);
		check("code_floor", {31'h0, code}, 36'h0_0000_0000);
		#2 imp_ref = 1'b1;
		repeat (32 * 1024 + 64) @(posedge ref_clk);
		check("code_ceiling", {31'h0, code}, 36'h0_0000_001F);
		conclude();
	end
endmodule
`default_nettype wire
